// ==== shared/gppc_cfg.svh ====
// register map, reset values and field positions of the pin port controller
// assumes 8-bit byte addresses on a 32-bit register port, one word per register
`ifndef GPPC_CFG_SVH
`define GPPC_CFG_SVH

// port width and interrupt grouping
`define GPPC_PINS        32
`define GPPC_GRP_PINS    8
`define GPPC_NGRP        4
`define GPPC_NFUNC       4

// register groups: address bits [7:4]
`define GPPC_GRP_OWN     4'h0
`define GPPC_GRP_ODE     4'h1
`define GPPC_GRP_OLV     4'h2
`define GPPC_GRP_PLV     4'h3
`define GPPC_GRP_IEN     4'h4
`define GPPC_GRP_IMD0    4'h5
`define GPPC_GRP_IMD1    4'h6
`define GPPC_GRP_GFE     4'h7
`define GPPC_GRP_IFL     4'h8
`define GPPC_GRP_PUE     4'h9
`define GPPC_GRP_PDE     4'ha
`define GPPC_GRP_DST0    4'hb
`define GPPC_GRP_DST1    4'hc
`define GPPC_GRP_PMX0    4'hd
`define GPPC_GRP_PMX1    4'he
`define GPPC_GRP_LCK     4'hf

// access kind within a group: address bits [3:2]
`define GPPC_SUB_WR      2'h0
`define GPPC_SUB_SET     2'h1
`define GPPC_SUB_CLR     2'h2
`define GPPC_SUB_TGL     2'h3

// reset values
`define GPPC_RST_OWN     32'hffff_ffff
`define GPPC_RST_ZERO    32'h0000_0000

// interrupt mode codes {mode1, mode0}
`define GPPC_IMD_CHG     2'h0
`define GPPC_IMD_RISE    2'h1
`define GPPC_IMD_FALL    2'h2

`endif

// ==== shared/gppc_pkg.sv ====
// types shared by the pin port controller and its input filter
// assumes gppc_cfg.svh for widths
`default_nettype none
`include "gppc_cfg.svh"

package gppc_pkg;

  typedef logic [`GPPC_PINS-1:0] gppc_word_t;  // one bit per pin

  // kind of register access, decoded from the address
  typedef enum logic [3:0] {
    GPPC_ACC_WR  = 4'b0001,
    GPPC_ACC_SET = 4'b0010,
    GPPC_ACC_CLR = 4'b0100,
    GPPC_ACC_TGL = 4'b1000
  } gppc_acc_e;

  // state of the input sampler
  typedef struct packed {
    gppc_word_t s1;   // first sync stage
    gppc_word_t s2;   // second sync stage
    gppc_word_t s3;   // previous s2, for the filter
    gppc_word_t flt;  // filtered level
    gppc_word_t prv;  // last level seen by edge detect
  } gppc_filt_s;

  // state of the controller
  typedef struct packed {
    gppc_word_t                own;   // controller ownership
    gppc_word_t                ode;   // output drive enable
    gppc_word_t                olv;   // output level
    gppc_word_t                plv;   // pin level
    gppc_word_t                ien;   // pin interrupt enable
    gppc_word_t                imd0;  // interrupt mode bit 0
    gppc_word_t                imd1;  // interrupt mode bit 1
    gppc_word_t                gfe;   // glitch filter enable
    gppc_word_t                ifl;   // interrupt flags
    gppc_word_t                pue;   // pull-up enable
    gppc_word_t                pde;   // pull-down enable
    gppc_word_t                dst0;  // drive strength bit 0
    gppc_word_t                dst1;  // drive strength bit 1
    gppc_word_t                pmx0;  // function select bit 0
    gppc_word_t                pmx1;  // function select bit 1
    gppc_word_t                lck;   // configuration lock
    logic [31:0]               rdat;  // read data
    logic [`GPPC_NGRP-1:0]     irq;   // grouped requests
  } gppc_state_s;

endpackage
`default_nettype wire

// ==== design/gppc_pin_filt.sv ====
// pin input sampler: two-stage synchroniser, glitch filter, edge detect
// assumes pins are asynchronous to clk; ce freezes all state
`timescale 1ns/1ps
`default_nettype none
`include "gppc_cfg.svh"

module gppc_pin_filt
  import gppc_pkg::*;
(
  input  wire logic       clk,     // controller clock
  input  wire logic       rst,     // synchronous reset, high
  input  wire logic       ce,      // clock enable
  input  wire gppc_word_t pin_i,   // raw pin levels
  input  wire gppc_word_t gf_en,   // glitch filter enable per pin
  output gppc_word_t      lvl_o,   // synchronised level
  output gppc_word_t      rise_o,  // rising edge seen, pulse
  output gppc_word_t      fall_o   // falling edge seen, pulse
);

  gppc_filt_s st_q;  // registered state
  gppc_filt_s st_d;  // next state
  gppc_word_t irq_lvl;  // level fed to edge detect

  assign irq_lvl = (gf_en & st_q.flt) | (~gf_en & st_q.s2);
  assign lvl_o   = st_q.s2;
  assign rise_o  = irq_lvl & ~st_q.prv;
  assign fall_o  = ~irq_lvl & st_q.prv;

  // next state
  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.s1  = pin_i;
      st_d.s2  = st_q.s1;
      st_d.s3  = st_q.s2;
      // accept only levels held two edges
      st_d.flt = (~(st_q.s2 ^ st_q.s3) & st_q.s2)
               | ((st_q.s2 ^ st_q.s3) & st_q.flt);
      st_d.prv = irq_lvl;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule // gppc_pin_filt
`default_nettype wire

// ==== design/gppc_top.sv ====
// pin port controller: 32 pins, register port, local bus, pin interrupts
// assumes one clock; pins and peripheral lines enter asynchronously
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gppc_cfg.svh"

module gppc_top
  import gppc_pkg::*;
(
  input  wire logic                    clk,       // controller clock
  input  wire logic                    rst,       // sync reset, high
  input  wire logic                    ce,        // clock enable
  input  wire logic [7:0]              pb_addr,   // register byte address
  input  wire logic [31:0]             pb_wdata,  // register write data
  input  wire logic                    pb_we,     // write strobe
  input  wire logic                    pb_re,     // read strobe
  output logic [31:0]                  pb_rdata,  // read data, next cycle
  input  wire logic [7:0]              lb_addr,   // local bus address
  input  wire logic [31:0]             lb_wdata,  // local bus write data
  input  wire logic                    lb_we,     // local bus write strobe
  input  wire gppc_word_t              io_pin_n_i,   // pin levels in
  output gppc_word_t                   io_pin_n_o,   // pin levels out
  output gppc_word_t                   io_pin_n_oe,  // pin drive enables
  input  wire logic [4*`GPPC_PINS-1:0] per_o,     // peripheral outputs
  input  wire logic [4*`GPPC_PINS-1:0] per_oe,    // peripheral enables
  output gppc_word_t                   pull_up,   // pull-up enables
  output gppc_word_t                   pull_dn,   // pull-down enables
  output gppc_word_t                   drv_lo,    // drive strength bit 0
  output gppc_word_t                   drv_hi,    // drive strength bit 1
  output logic [`GPPC_NGRP-1:0]        irq        // grouped requests
);

  // each register is one 32-bit word, bit per pin
  gppc_state_s st_q;     // registered state
  gppc_state_s st_d;     // next state
  gppc_word_t  lvl;      // synchronised pin levels
  gppc_word_t  rise;     // rising edges
  gppc_word_t  fall;     // falling edges
  gppc_word_t  hit;      // interrupt events this cycle
  gppc_word_t  sel_o;    // selected peripheral output
  gppc_word_t  sel_oe;   // selected peripheral enable
  gppc_word_t  upd;      // level bits allowed to refresh
  logic [3:0]  pb_grp;   // register group
  logic [1:0]  pb_sub;   // access kind
  logic [3:0]  lb_grp;   // local bus group
  logic [1:0]  lb_sub;   // local bus access kind

  // address split
  assign pb_grp = pb_addr[7:4];
  assign pb_sub = pb_addr[3:2];
  assign lb_grp = lb_addr[7:4];
  assign lb_sub = lb_addr[3:2];

  // access kind from the address bits
  function automatic gppc_acc_e gppc_kind(input logic [1:0] sub);
    gppc_acc_e k;
    unique case (sub)
      `GPPC_SUB_SET: k = GPPC_ACC_SET;
      `GPPC_SUB_CLR: k = GPPC_ACC_CLR;
      `GPPC_SUB_TGL: k = GPPC_ACC_TGL;
      default:       k = GPPC_ACC_WR;
    endcase
    return k;
  endfunction

  // word, set, clear or toggle write, locked bits kept
  function automatic gppc_word_t gppc_apply(
    input gppc_word_t  old,
    input gppc_word_t  wd,
    input logic [1:0]  sub,
    input gppc_word_t  lk
  );
    gppc_word_t nw;
    nw = old;
    unique case (gppc_kind(sub))
      GPPC_ACC_WR:  nw = wd;
      GPPC_ACC_SET: nw = old | wd;
      GPPC_ACC_CLR: nw = old & ~wd;
      GPPC_ACC_TGL: nw = old ^ wd;
    endcase
    // locked bits stay as they were
    return (nw & ~lk) | (old & lk);
  endfunction

  // input sampling, filtering and edge detect
  gppc_pin_filt u_filt (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .pin_i  (io_pin_n_i),
    .gf_en  (st_q.gfe),
    .lvl_o  (lvl),
    .rise_o (rise),
    .fall_o (fall)
  );

  // peripheral function select per pin
  always_comb begin
    sel_o  = '0;
    sel_oe = '0;
    for (int p = 0; p < `GPPC_PINS; p++) begin
      sel_o[p]  = per_o[{st_q.pmx1[p], st_q.pmx0[p]} * `GPPC_PINS + p];
      sel_oe[p] = per_oe[{st_q.pmx1[p], st_q.pmx0[p]} * `GPPC_PINS + p];
    end
  end

  // pin drive: a mux only, so peripherals keep working without clock
  // peripheral path bypasses clocked logic
  // owned pins drive the output level
  assign io_pin_n_o  = (st_q.own & st_q.olv) | (~st_q.own & sel_o);
  assign io_pin_n_oe = (st_q.own & st_q.ode) | (~st_q.own & sel_oe);

  assign pull_up  = st_q.pue;
  assign pull_dn  = st_q.pde;
  assign drv_lo   = st_q.dst0;
  assign drv_hi   = st_q.dst1;
  assign irq      = st_q.irq;
  assign pb_rdata = st_q.rdat;

  // mode 11 selects no event at all
  // mode decode per pin
  assign hit = st_q.ien & (
      (~st_q.imd1 & ~st_q.imd0 & (rise | fall))
    | (~st_q.imd1 &  st_q.imd0 & rise)
    | ( st_q.imd1 & ~st_q.imd0 & fall));

  // refresh only owned or interrupt enabled pins
  assign upd = st_q.own | st_q.ien;

  // next state: bus writes, local bus, level, flags, reads
  always_comb begin
    st_d = st_q;
    // nothing moves while ce is low
    if (ce) begin
      // read data stands for one cycle only
      st_d.rdat = 32'h0000_0000;
      if (pb_we) begin
        unique case (pb_grp)
          `GPPC_GRP_OWN:  st_d.own  = gppc_apply(st_q.own, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_ODE:  st_d.ode  = gppc_apply(st_q.ode, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_OLV:  st_d.olv  = gppc_apply(st_q.olv, pb_wdata,
                                                 pb_sub, '0);
          `GPPC_GRP_IEN:  st_d.ien  = gppc_apply(st_q.ien, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_IMD0: st_d.imd0 = gppc_apply(st_q.imd0, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_IMD1: st_d.imd1 = gppc_apply(st_q.imd1, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_GFE:  st_d.gfe  = gppc_apply(st_q.gfe, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_PUE:  st_d.pue  = gppc_apply(st_q.pue, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_PDE:  st_d.pde  = gppc_apply(st_q.pde, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_DST0: st_d.dst0 = gppc_apply(st_q.dst0, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_DST1: st_d.dst1 = gppc_apply(st_q.dst1, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_PMX0: st_d.pmx0 = gppc_apply(st_q.pmx0, pb_wdata,
                                                 pb_sub, st_q.lck);
          `GPPC_GRP_PMX1: st_d.pmx1 = gppc_apply(st_q.pmx1, pb_wdata,
                                                 pb_sub, st_q.lck);
          // flags: word write of zero or clear alias clears
          `GPPC_GRP_IFL: begin
            if (pb_sub == `GPPC_SUB_WR) begin
              st_d.ifl = st_q.ifl & pb_wdata;
            end else if (pb_sub == `GPPC_SUB_CLR) begin
              st_d.ifl = st_q.ifl & ~pb_wdata;
            end
          end
          // lock only gathers bits until reset
          `GPPC_GRP_LCK: begin
            if (pb_sub == `GPPC_SUB_WR || pb_sub == `GPPC_SUB_SET) begin
              st_d.lck = st_q.lck | pb_wdata;
            end
          end
          // level register is read-only
          default: st_d.plv = st_q.plv;
        endcase
      end
      // local bus applied last, so it wins a tie
      // local bus shares clk, so no crossing here
      // local bus writes output level and enable
      if (lb_we) begin
        if (lb_grp == `GPPC_GRP_OLV) begin
          st_d.olv = gppc_apply(st_d.olv, lb_wdata, lb_sub, '0);
        end else if (lb_grp == `GPPC_GRP_ODE) begin
          st_d.ode = gppc_apply(st_d.ode, lb_wdata, lb_sub, st_q.lck);
        end
      end
      // level of owned or interrupt enabled pins, any driver
      // refresh gated by ownership or enable
      st_d.plv = (upd & lvl) | (~upd & st_q.plv);
      // new events win over a clear
      st_d.ifl = st_d.ifl | hit;
      // request registered with the flags it reflects
      // groups of eight onto request lines
      for (int g = 0; g < `GPPC_NGRP; g++) begin
        st_d.irq[g] = |(st_d.ifl[g*`GPPC_GRP_PINS +: `GPPC_GRP_PINS]
                      & st_d.ien[g*`GPPC_GRP_PINS +: `GPPC_GRP_PINS]);
      end
      // register read, base address of each group only
      if (pb_re && pb_sub == `GPPC_SUB_WR) begin
        unique case (pb_grp)
          `GPPC_GRP_OWN:  st_d.rdat = st_q.own;
          `GPPC_GRP_ODE:  st_d.rdat = st_q.ode;
          `GPPC_GRP_OLV:  st_d.rdat = st_q.olv;
          `GPPC_GRP_PLV:  st_d.rdat = st_q.plv;
          `GPPC_GRP_IEN:  st_d.rdat = st_q.ien;
          `GPPC_GRP_IMD0: st_d.rdat = st_q.imd0;
          `GPPC_GRP_IMD1: st_d.rdat = st_q.imd1;
          `GPPC_GRP_GFE:  st_d.rdat = st_q.gfe;
          `GPPC_GRP_IFL:  st_d.rdat = st_q.ifl;
          `GPPC_GRP_PUE:  st_d.rdat = st_q.pue;
          `GPPC_GRP_PDE:  st_d.rdat = st_q.pde;
          `GPPC_GRP_DST0: st_d.rdat = st_q.dst0;
          `GPPC_GRP_DST1: st_d.rdat = st_q.dst1;
          `GPPC_GRP_PMX0: st_d.rdat = st_q.pmx0;
          `GPPC_GRP_PMX1: st_d.rdat = st_q.pmx1;
          `GPPC_GRP_LCK:  st_d.rdat = st_q.lck;
        endcase
      end
    end
  end

  // state register
  // reset wins over a low clock enable
  always_ff @(posedge clk) begin
    if (rst) begin
      // usable from the first edge after reset
      st_q      <= '0;
      st_q.own  <= `GPPC_RST_OWN;
    end else begin
      st_q <= st_d;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // register port, level hold and clock enable checks
  read_back_a: assert property (
    ce && pb_re && pb_addr == {`GPPC_GRP_OWN, `GPPC_SUB_WR, 2'b00}
    |=> pb_rdata == $past(st_q.own))
    else $error("read data does not match ownership");

  set_alias_a: assert property (
    ce && pb_we && pb_addr == {`GPPC_GRP_OWN, `GPPC_SUB_SET, 2'b00}
    |=> st_q.own == ($past(st_q.own) | ($past(pb_wdata) & ~$past(st_q.lck))))
    else $error("set alias wrong");

  level_hold_a: assert property (
    ce |=> ((st_q.plv ^ $past(st_q.plv)) & ~$past(upd)) == '0)
    else $error("level bit changed while not refreshed");

  halt_all_a: assert property (
    !ce |=> $stable(st_q))
    else $error("state moved with clock enable low");

  // pin drive, flag, lock, request, local bus and read data checks
  periph_drive_a: assert property (
    (io_pin_n_oe & ~st_q.own) == (sel_oe & ~st_q.own))
    else $error("peripheral enable not passed through");

  owned_level_a: assert property (
    ((io_pin_n_o ^ st_q.olv) & st_q.own & st_q.ode) == '0)
    else $error("owned pin drives wrong level");

  flag_set_a: assert property (
    ce |=> (st_q.ifl & $past(hit)) == $past(hit))
    else $error("interrupt event lost");

  lock_hold_a: assert property (
    ce && pb_we && pb_grp == `GPPC_GRP_OWN
    |=> ((st_q.own ^ $past(st_q.own)) & $past(st_q.lck)) == '0)
    else $error("locked bit rewritten");

  irq_group_a: assert property (
    ce |=> irq[0] == |(st_q.ifl[7:0] & st_q.ien[7:0]))
    else $error("group request wrong");

  local_bus_a: assert property (
    ce && lb_we && !pb_we
    && lb_addr == {`GPPC_GRP_OLV, `GPPC_SUB_WR, 2'b00}
    |=> st_q.olv == $past(lb_wdata))
    else $error("local bus write lost");

  rdat_idle_a: assert property (
    ce && !pb_re |=> pb_rdata == 32'h0000_0000)
    else $error("read data not cleared after read");

  lock_keep_a: assert property (
    ce |=> (~st_q.lck & $past(st_q.lck)) == '0)
    else $error("lock bit cleared");

  irq_upper_a: assert property (
    ce |=> irq[3] == |(st_q.ifl[31:24] & st_q.ien[31:24]))
    else $error("upper group request wrong");

  owned_off_a: assert property (
    (io_pin_n_oe & st_q.own & ~st_q.ode) == '0)
    else $error("owned pin driven without enable");

  rise_irq_c: cover property (ce && |(rise & st_q.ien) ##1 |irq);
  lock_c: cover property (ce && pb_we && pb_grp == `GPPC_GRP_LCK);
  periph_c: cover property (|(~st_q.own & sel_oe));
  lb_c: cover property (ce && lb_we && pb_we);
  fall_c: cover property (ce && |(fall & st_q.ien) ##1 |irq);

endmodule // gppc_top
`default_nettype wire

// ==== sim/gppc_pin_env.sv ====
// pin nets outside the controller: external drivers, pulls, floating
// assumes the controller's own drive wins over the external driver
`timescale 1ns/1ps
`default_nettype none
module gppc_pin_env
  import gppc_pkg::*;
(
  input  wire logic       clk,     // controller clock
  input  wire gppc_word_t dut_o,   // controller pin level
  input  wire gppc_word_t dut_oe,  // controller drive enable
  input  wire gppc_word_t pu,      // pull-up enables
  input  wire gppc_word_t pd,      // pull-down enables
  input  wire gppc_word_t ext_o,   // external driver level
  input  wire gppc_word_t ext_oe,  // external driver enable
  output gppc_word_t      lvl      // resolved net level
);
  gppc_word_t flt_q = '0;  // undriven nets wander each cycle

  // an undriven net must not look stable
  always @(posedge clk) flt_q <= ~flt_q;

  // resolve each net from all parties
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (dut_oe[i]) lvl[i] = dut_o[i];
      else if (ext_oe[i]) lvl[i] = ext_o[i];
      else if (pu[i]) lvl[i] = 1'b1;
      else if (pd[i]) lvl[i] = 1'b0;
      else lvl[i] = flt_q[i];
    end
  end
endmodule // gppc_pin_env
`default_nettype wire

// ==== sim/gppc_pin_port_controller_tb.sv ====
// self-checking bench of the pin port controller
// assumes gppc_pkg compiled first; pins resolved by gppc_pin_env
`timescale 1ns/1ps
`default_nettype none
module gppc_pin_port_controller_tb;
  import gppc_pkg::*;
  logic         clk = 1'b0;  // 25 MHz clock
  logic         rst = 1'b1;  // sync reset
  logic         ce = 1'b1;   // clock enable
  logic [7:0]   pb_addr = '0, lb_addr = '0;
  logic [31:0]  pb_wdata = '0, lb_wdata = '0, pb_rdata;
  logic         pb_we = 1'b0, pb_re = 1'b0, lb_we = 1'b0;
  gppc_word_t   pin_i, pin_o, pin_oe, pu, pd, dlo, dhi;
  gppc_word_t   ext_o = '0, ext_oe = '1;  // external driver
  logic [127:0] per_o = '0, per_oe = '0;  // peripheral functions
  logic [3:0]   irq;
  int           miscompares = 0, n_checks = 0, cyc = 0;

  always #20 clk = ~clk;

  gppc_top u_dut (.clk(clk), .rst(rst), .ce(ce), .pb_addr(pb_addr),
    .pb_wdata(pb_wdata), .pb_we(pb_we), .pb_re(pb_re),
    .pb_rdata(pb_rdata), .lb_addr(lb_addr), .lb_wdata(lb_wdata),
    .lb_we(lb_we), .io_pin_n_i(pin_i), .io_pin_n_o(pin_o),
    .io_pin_n_oe(pin_oe), .per_o(per_o), .per_oe(per_oe),
    .pull_up(pu), .pull_dn(pd), .drv_lo(dlo), .drv_hi(dhi), .irq(irq));

  gppc_pin_env u_env (.clk(clk), .dut_o(pin_o), .dut_oe(pin_oe),
    .pu(pu), .pd(pd), .ext_o(ext_o), .ext_oe(ext_oe), .lvl(pin_i));

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    pb_we <= 1'b1;
    pb_addr <= a;
    pb_wdata <= d;
    @(posedge clk);
    pb_we <= 1'b0;
  endtask

  // read data is looked at in the one cycle it stands
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    pb_re <= 1'b1;
    pb_addr <= a;
    @(posedge clk);
    pb_re <= 1'b0;
    #1;
    chk($sformatf("read %h", a), e, pb_rdata);
  endtask

  task automatic lbw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    lb_we <= 1'b1;
    lb_addr <= a;
    lb_wdata <= d;
    @(posedge clk);
    lb_we <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // reset values of every word register except the level, which reads the pins
  task automatic t_reset;
    do_reset();
    ext_o <= 32'h3c3c_a5a5;
    waitc(5);
    chk("oe", 32'h0, pin_oe);
    chk("irq", 32'h0, {28'h0, irq});
    for (int g = 0; g < 16; g++)
      rd(8'(g * 16), (g == 0) ? 32'hffff_ffff :
         (g == 3) ? 32'h3c3c_a5a5 : 32'h0);
    rd(8'h04, 32'h0);
  endtask

  // bitwise aliases, pad controls, lock
  task automatic t_setclr;
    do_reset();
    wr(8'h20, 32'ha5a5_0f0f);
    wr(8'h24, 32'h0000_00f0);
    rd(8'h20, 32'ha5a5_0fff);
    wr(8'h28, 32'h0000_0f00);
    rd(8'h20, 32'ha5a5_00ff);
    wr(8'h2c, 32'hffff_0000);
    rd(8'h20, 32'h5a5a_00ff);
    wr(8'h90, 32'h1234_5678);
    wr(8'ha4, 32'h0000_ffff);
    wr(8'hbc, 32'h0000_000f);
    wr(8'hc0, 32'h8000_0000);
    waitc(1);
    chk("pull_up", 32'h1234_5678, pu);
    chk("pull_dn", 32'h0000_ffff, pd);
    chk("drv_lo", 32'h0000_000f, dlo);
    chk("drv_hi", 32'h8000_0000, dhi);
    wr(8'hf0, 32'h0000_00ff);
    wr(8'hf8, 32'h0000_00ff);
    rd(8'hf0, 32'h0000_00ff);
    wr(8'h90, 32'hffff_ffff);
    rd(8'h90, 32'hffff_ff78);
  endtask

  // drive ownership, peripheral functions, local bus, stopped clock
  task automatic t_drive;
    do_reset();
    wr(8'h10, 32'hffff_0000);
    wr(8'h20, 32'h5a5a_1234);
    waitc(1);
    chk("oe", 32'hffff_0000, pin_oe);
    chk("o", 32'h5a5a_0000, pin_o & pin_oe);
    lbw(8'h24, 32'h0001_0000);
    waitc(1);
    chk("lb", 32'h5a5b_0000, pin_o & pin_oe);
    per_o <= {32'h0, 32'h96, 32'h0, 32'ha5};
    per_oe <= {32'h0, 32'hff, 32'h0, 32'hff};
    wr(8'h08, 32'h0000_00ff);
    waitc(1);
    chk("per_oe", 32'hffff_00ff, pin_oe);
    chk("fn0", 32'h5a5b_00a5, pin_o & pin_oe);
    wr(8'he4, 32'h0000_00ff);
    waitc(1);
    chk("fn2", 32'h5a5b_0096, pin_o & pin_oe);
    ce <= 1'b0;
    per_o[71:64] <= 8'h3c;
    wr(8'h20, 32'h0);
    waitc(1);
    chk("stopped", 32'h5a5b_003c, pin_o & pin_oe);
    ce <= 1'b1;
    rd(8'h20, 32'h5a5b_1234);
    // peripherals go quiet so later pins follow the external driver
    per_o <= '0;
    per_oe <= '0;
  endtask

  // level register refresh condition and sync delay
  task automatic t_level;
    ext_o <= 32'h0;
    do_reset();
    wr(8'h08, 32'h0000_ff00);
    ext_o <= 32'hffff_ffff;
    waitc(4);
    rd(8'h30, 32'hffff_00ff);
    wr(8'h30, 32'h0);
    wr(8'h44, 32'h0000_ff00);
    waitc(4);
    rd(8'h30, 32'hffff_ffff);
    wr(8'h48, 32'h0000_f000);
    ext_o <= 32'h0;
    rd(8'h30, 32'hffff_ffff);
    waitc(4);
    rd(8'h30, 32'h0000_f000);
  endtask

  // every mode on a peripheral-owned pin, one per group
  task automatic t_irq;
    int          p;
    logic [31:0] b;
    logic [31:0] g;
    for (int m = 0; m < 4; m++) begin
      do_reset();
      p = 8 * m + 3;
      b = 32'h1 << p;
      g = 32'h1 << m;
      ext_o <= 32'h0;
      wr(8'h08, b);
      if (m[0]) wr(8'h54, b);
      if (m[1]) wr(8'h64, b);
      wr(8'h44, b);
      waitc(4);
      ext_o <= b;
      waitc(8);
      chk("irq_rise", (m < 2) ? g : 32'h0, {28'h0, irq});
      rd(8'h80, (m < 2) ? b : 32'h0);
      wr(8'h88, b);
      waitc(2);
      chk("irq_clr", 32'h0, {28'h0, irq});
      ext_o <= 32'h0;
      waitc(8);
      chk("irq_fall", (m == 0 || m == 2) ? g : 32'h0, {28'h0, irq});
    end
  endtask

  // one-cycle pulse rejected, three-cycle pulse accepted
  task automatic t_glitch;
    do_reset();
    ext_o <= 32'h0;
    wr(8'h74, 32'h1);
    wr(8'h44, 32'h1);
    waitc(4);
    ext_o <= 32'h1;
    @(posedge clk);
    ext_o <= 32'h0;
    waitc(8);
    rd(8'h80, 32'h0);
    ext_o <= 32'h1;
    waitc(3);
    ext_o <= 32'h0;
    waitc(8);
    rd(8'h80, 32'h1);
    chk("irq_g", 32'h1, {28'h0, irq});
    wr(8'h80, 32'h0);
    rd(8'h80, 32'h0);
  endtask

  initial begin
    t_reset();
    t_setclr();
    t_drive();
    t_level();
    t_irq();
    t_glitch();
    summarize();
  end
endmodule // gppc_pin_port_controller_tb
`default_nettype wire
